// File: rtl/amd_ctrl.sv
// mode control and turn-on diagnostic sequencer of a quad amplifier
`timescale 1ns/10ps
`include "amd_defs.svh"
module amd_ctrl #(
  parameter int FS_HZ = `AMD_FS_HZ,
  parameter int SH_TICKS = `AMD_SH_MS * `AMD_FS_HZ / 1000,
  parameter int PL_TICKS = `AMD_PL_MS * `AMD_FS_HZ / 1000,
  parameter int DLY_TICKS = `AMD_DLY_MS * `AMD_FS_HZ / 1000,
  parameter int RISE_TICKS = `AMD_RISE_MS * `AMD_FS_HZ / 1000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable_pin,
  input wire logic sample_clk,
  input wire logic [7:0] diag_control_byte,
  input wire logic [7:0] mode_control_byte,
  input wire logic status_read,
  input wire amd_pkg::amd_fault_t [3:0] fault_spk,
  input wire logic [3:0] fault_boost_load,
  input wire logic [3:0] short_event,
  output logic [7:0] channel1_status_byte,
  output amd_pkg::amd_fault_t [3:0] chan_fault,
  output amd_pkg::amd_mode_t mode,
  output logic outputs_hiz,
  output logic [3:0] chan_mute,
  output logic enable_pin_out,
  output logic enable_pin_oe,
  output logic enable_pin_source,
  output logic diag_busy,
  output logic [3:0] booster_sel
);
  import amd_pkg::*;

  function automatic logic [17:0] phase_len(input amd_diag_t s);
    phase_len = 18'h00000;
    unique case (s)
      AMD_RISE: phase_len = 18'(RISE_TICKS);
      AMD_SHORT: phase_len = 18'(SH_TICKS);
      AMD_PLATEAU: phase_len = 18'(PL_TICKS);
      AMD_DELAY: phase_len = 18'(DLY_TICKS);
      AMD_IDLE: phase_len = 18'h00000;
    endcase
  endfunction : phase_len

  // reset release and pin synchronisers
  logic rst_m, rst_s;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m <= 1'b0;
      rst_s <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_s <= rst_m;
    end
  end

  logic en_m, en_s, fs_m, fs_s, fs_d;
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      en_m <= 1'b0;
      en_s <= 1'b0;
      fs_m <= 1'b0;
      fs_s <= 1'b0;
      fs_d <= 1'b0;
    end else begin
      en_m <= enable_pin;
      en_s <= en_m;
      fs_m <= sample_clk;
      fs_s <= fs_m;
      fs_d <= fs_s;
    end
  end
  logic fs_tick;
  assign fs_tick = fs_s & ~fs_d; // one sample period

  // state
  amd_diag_t dstate, next_dstate;
  amd_mode_t next_mode;
  logic [17:0] cnt, next_cnt;
  logic start_d, next_start_d;
  logic active, next_active;
  logic valid, next_valid;
  amd_fault_t [3:0] next_chan_fault;
  logic [3:0] next_mute;
  logic next_busy, next_hiz, next_pin_out, next_pin_oe, next_source;
  logic [3:0] next_booster;
  logic [7:0] next_status;
  logic start_bit, amp_bit, start_rise;
  amd_fault_t res;

  assign start_bit = diag_control_byte[`AMD_START_BIT];
  assign amp_bit = mode_control_byte[`AMD_AMP_BIT];
  assign start_rise = start_bit & ~start_d;

  // next values of mode, sequencer and result registers
  always_comb begin
    next_dstate = dstate;
    next_cnt = cnt;
    next_start_d = start_bit;
    next_active = active;
    next_valid = valid;
    next_chan_fault = chan_fault;
    next_mute = chan_mute;
    next_source = 1'b0;
    next_booster[0] = diag_control_byte[`AMD_PAIR13_BIT];
    next_booster[2] = diag_control_byte[`AMD_PAIR13_BIT];
    next_booster[1] = diag_control_byte[`AMD_PAIR24_BIT];
    next_booster[3] = diag_control_byte[`AMD_PAIR24_BIT];
    res = '0;
    // a read clears the results, but a latch in the same cycle
    // is applied after this and so wins over the read
    if (status_read) begin
      next_chan_fault = '0;
      next_valid = 1'b0;
    end
    unique case (dstate)
      AMD_IDLE: begin
        if (start_rise && mode == AMD_TRISTATE) begin
          next_dstate = AMD_RISE;
          next_cnt = '0;
          next_chan_fault = '0;
          next_valid = 1'b0;
        end
      end
      default: begin
        // start writes have no effect here
        if (fs_tick) begin
          if (cnt + 18'h00001 >= phase_len(dstate)) begin
            next_cnt = '0;
            unique case (dstate)
              AMD_RISE: next_dstate = AMD_SHORT;
              AMD_SHORT: next_dstate = AMD_PLATEAU;
              AMD_PLATEAU: begin
                next_dstate = AMD_DELAY;
                for (int i = 0; i < 4; i++) begin
                  res = fault_spk[i];
                  if (booster_sel[i]) begin
                    res.short_load = fault_boost_load[i] & ~fault_spk[i].open_load;
                  end
                  next_chan_fault[i] = res;
                end
                next_valid = 1'b1;
              end
              AMD_DELAY: next_dstate = AMD_IDLE;
              default: next_dstate = AMD_IDLE;
            endcase
          end else begin
            next_cnt = cnt + 18'h00001;
          end
        end
      end
    endcase
    // mode selection: enable low overrides everything, including a
    // running sequence, so the sequencer is sent back to idle
    // the amplifier request is held off while a start edge is pending,
    // so a combined write in tristate runs the diagnostic first
    if (!en_s) begin
      next_active = 1'b0;
      next_dstate = AMD_IDLE;
      next_cnt = '0;
      next_mute = 4'hf;
      next_source = (mode == AMD_AMPLIFIER);
    end else if (!active && amp_bit && (dstate == AMD_IDLE) && !start_rise) begin
      next_active = 1'b1;
      next_mute = 4'hf;
    end else if (active && !amp_bit) begin
      next_active = 1'b0;
    end
    // permanent diagnostic: a short replaces the kept turn-on result
    if (active) begin
      for (int i = 0; i < 4; i++) begin
        if (short_event[i]) begin
          next_chan_fault[i] = '0;
          next_chan_fault[i].short_load = 1'b1;
        end
      end
    end
    if (!en_s) begin
      next_mode = AMD_STANDBY;
    end else if (next_active) begin
      next_mode = AMD_AMPLIFIER;
    end else begin
      next_mode = AMD_TRISTATE;
    end
    next_hiz = (next_mode != AMD_AMPLIFIER);
    next_pin_oe = (next_mode == AMD_AMPLIFIER) | next_source;
    next_pin_out = next_pin_oe;
    next_busy = (next_dstate != AMD_IDLE);
    next_status = '0;
    next_status[`AMD_ACTIVE_BIT] = next_active;
    next_status[`AMD_VALID_BIT] = next_valid;
    next_status[4:0] = next_chan_fault[0];
  end

  // registers
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      dstate <= AMD_IDLE;
      cnt <= '0;
      start_d <= 1'b0;
      active <= 1'b0;
      valid <= 1'b0;
      chan_fault <= '0;
      chan_mute <= 4'hf;
      mode <= AMD_STANDBY;
      outputs_hiz <= 1'b1;
      enable_pin_out <= 1'b0;
      enable_pin_oe <= 1'b0;
      enable_pin_source <= 1'b0;
      diag_busy <= 1'b0;
      booster_sel <= '0;
      channel1_status_byte <= '0;
    end else begin
      dstate <= next_dstate;
      cnt <= next_cnt;
      start_d <= next_start_d;
      active <= next_active;
      valid <= next_valid;
      chan_fault <= next_chan_fault;
      chan_mute <= next_mute;
      mode <= next_mode;
      outputs_hiz <= next_hiz;
      enable_pin_out <= next_pin_out;
      enable_pin_oe <= next_pin_oe;
      enable_pin_source <= next_source;
      diag_busy <= next_busy;
      booster_sel <= next_booster;
      channel1_status_byte <= next_status;
    end
  end

  // checks
  standby_mode_a: assert property (@(posedge clk) disable iff (!rst_s)
    !en_s |=> mode == AMD_STANDBY) else $error("standby not entered");
  tristate_hiz_a: assert property (@(posedge clk) disable iff (!rst_s)
    mode == AMD_TRISTATE |-> outputs_hiz) else $error("tristate not hiz");
  amp_active_a: assert property (@(posedge clk) disable iff (!rst_s)
    mode == AMD_AMPLIFIER |-> channel1_status_byte[7]) else $error("active bit");
  amp_muted_a: assert property (@(posedge clk) disable iff (!rst_s)
    $rose(mode == AMD_AMPLIFIER) |-> chan_mute == 4'hf) else $error("not muted");
  pin_drive_a: assert property (@(posedge clk) disable iff (!rst_s)
    mode == AMD_AMPLIFIER |-> enable_pin_oe) else $error("pin not driven");
  start_gate_a: assert property (@(posedge clk) disable iff (!rst_s)
    dstate == AMD_IDLE && next_dstate == AMD_RISE |-> mode == AMD_TRISTATE && start_rise)
    else $error("bad start");
  no_restart_a: assert property (@(posedge clk) disable iff (!rst_s)
    dstate != AMD_IDLE && en_s |=> dstate != AMD_RISE || $past(dstate) == AMD_RISE)
    else $error("restart");
  latch_end_a: assert property (@(posedge clk) disable iff (!rst_s)
    dstate == AMD_PLATEAU ##1 dstate == AMD_DELAY |-> valid) else $error("no latch");
  read_clear_a: assert property (@(posedge clk) disable iff (!rst_s)
    status_read && dstate != AMD_PLATEAU && !active |=> !valid) else $error("no clear");
  bound_cnt_a: assert property (@(posedge clk) disable iff (!rst_s)
    cnt <= 18'(PL_TICKS)) else $error("phase overrun");

  // standby keeps the outputs off and all channels muted
  stby_quiet_a: assert property (@(posedge clk) disable iff (!rst_s)
    mode == AMD_STANDBY |-> outputs_hiz && chan_mute == 4'hf)
    else $error("standby not quiet");

  // tristate reports the amplifier-active bit clear
  tri_status_a: assert property (@(posedge clk) disable iff (!rst_s)
    mode == AMD_TRISTATE |-> !channel1_status_byte[7])
    else $error("tristate active bit");

  // amplifier mode releases the outputs
  amp_drive_a: assert property (@(posedge clk) disable iff (!rst_s)
    mode == AMD_AMPLIFIER |-> !outputs_hiz)
    else $error("amplifier outputs hiz");

  // the pin is only ever driven to its own high level
  pin_level_a: assert property (@(posedge clk) disable iff (!rst_s)
    enable_pin_oe |-> enable_pin_out)
    else $error("pin level");

  // current sourcing only accompanies the fall into standby
  source_stby_a: assert property (@(posedge clk) disable iff (!rst_s)
    enable_pin_source |-> mode == AMD_STANDBY && enable_pin_oe)
    else $error("source outside leave");

  // a running sequence only ever belongs to tristate
  busy_tri_a: assert property (@(posedge clk) disable iff (!rst_s)
    diag_busy |-> mode == AMD_TRISTATE)
    else $error("busy outside tristate");

  // a start bit that simply stays high never starts a new cycle
  level_hold_a: assert property (@(posedge clk) disable iff (!rst_s)
    dstate == AMD_IDLE && start_d && start_bit |=> dstate == AMD_IDLE)
    else $error("level retrigger");

  // pair selection follows the two control bits one cycle later
  pair_select_a: assert property (@(posedge clk) disable iff (!rst_s)
    1'b1 |=> booster_sel == {2{$past(diag_control_byte[`AMD_PAIR24_BIT]),
    $past(diag_control_byte[`AMD_PAIR13_BIT])}})
    else $error("pair select");

  // the consistency flag in the status byte mirrors the latch
  valid_flag_a: assert property (@(posedge clk) disable iff (!rst_s)
    channel1_status_byte[`AMD_VALID_BIT] == valid)
    else $error("valid flag");

  // an output short in amplifier mode replaces the kept result
  short_swap_a: assert property (@(posedge clk) disable iff (!rst_s)
    active && short_event[2] |=> chan_fault[2].short_load)
    else $error("short not recorded");

  diag_run_c: cover property (@(posedge clk) disable iff (!rst_s) $fell(diag_busy));
  amp_enter_c: cover property (@(posedge clk) disable iff (!rst_s) $rose(mode == AMD_AMPLIFIER));
  source_c: cover property (@(posedge clk) disable iff (!rst_s) enable_pin_source);
  // a status read that clears latched results
  read_c: cover property (@(posedge clk) disable iff (!rst_s)
    status_read && valid);
  // a short reported during amplifier mode
  short_c: cover property (@(posedge clk) disable iff (!rst_s)
    active && short_event != 4'h0);
endmodule : amd_ctrl

// File: rtl/amd_defs.svh
// constants for the amplifier mode and turn-on diagnostic sequencer
`ifndef AMD_DEFS_SVH
`define AMD_DEFS_SVH
`define AMD_START_BIT 7
`define AMD_PAIR13_BIT 6
`define AMD_PAIR24_BIT 5
`define AMD_AMP_BIT 7
`define AMD_ACTIVE_BIT 7
`define AMD_VALID_BIT 6
`define AMD_FS_HZ 44100
`define AMD_SH_MS 5
`define AMD_PL_MS 162
`define AMD_DLY_MS 5
`define AMD_RISE_MS 5
`define AMD_MAX_MS 190
`endif

// File: rtl/amd_pkg.sv
// types for the amplifier mode and turn-on diagnostic sequencer
package amd_pkg;
  typedef enum logic [2:0] {
    AMD_STANDBY = 3'b001,
    AMD_TRISTATE = 3'b010,
    AMD_AMPLIFIER = 3'b100
  } amd_mode_t;
  typedef enum logic [4:0] {
    AMD_IDLE = 5'b00001,
    AMD_RISE = 5'b00010,
    AMD_SHORT = 5'b00100,
    AMD_PLATEAU = 5'b01000,
    AMD_DELAY = 5'b10000
  } amd_diag_t;
  typedef struct packed {
    logic short_gnd;
    logic short_vs;
    logic short_load;
    logic open_load;
    logic normal;
  } amd_fault_t;
endpackage : amd_pkg

// File: testbench/amd_host.sv
// host-side model: enable pin, control bytes and status reads
`timescale 1ns/10ps
module amd_host (
  input wire logic clk,
  output logic host_en,
  output logic [7:0] diag_byte,
  output logic [7:0] mode_byte,
  output logic status_read
);
  // idle values at time zero
  initial begin
    host_en = 1'b0;
    diag_byte = 8'h00;
    mode_byte = 8'h00;
    status_read = 1'b0;
  end
  // pin level changes on the falling edge
  task automatic set_en(input logic v);
    @(negedge clk) host_en = v;
  endtask : set_en
  // both bytes land together, so start is never later than mode
  task automatic write_bytes(input logic [7:0] d, input logic [7:0] m);
    @(negedge clk);
    diag_byte = d;
    mode_byte = m;
  endtask : write_bytes
  // one-cycle read strobe clears results between sequences
  task automatic read_status();
    @(negedge clk) status_read = 1'b1;
    @(negedge clk) status_read = 1'b0;
  endtask : read_status
endmodule : amd_host

// File: testbench/tb_top.sv
// self-checking bench for the mode control and diagnostic sequencer
`timescale 1ns/10ps
module tb_top;
  import amd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sample_clk = 1'b0;
  logic host_en, status_read, enable_pin, hiz, pin_out, pin_oe, pin_src, busy;
  logic [7:0] diag_byte, mode_byte, status_byte;
  logic [3:0] boost_load = 4'h0;
  logic [3:0] short_ev = 4'h0;
  logic [3:0] chan_mute, booster_sel;
  amd_fault_t [3:0] fault_spk = '0;
  amd_fault_t [3:0] chan_fault;
  amd_mode_t mode;
  int n_fail = 0;
  int checked = 0;
  // system clock and free-running sample clock
  always #5 clk = ~clk;
  always #80 sample_clk = ~sample_clk;
  // pin level: host drives always, device drives while oe is high
  assign enable_pin = pin_oe ? (pin_out & host_en) : host_en;
  amd_host host (.clk(clk), .host_en(host_en), .diag_byte(diag_byte),
    .mode_byte(mode_byte), .status_read(status_read));
  amd_ctrl #(.SH_TICKS(2), .PL_TICKS(3), .DLY_TICKS(2), .RISE_TICKS(2)) dut (
    .clk(clk), .rst_n(rst_n), .enable_pin(enable_pin), .sample_clk(sample_clk),
    .diag_control_byte(diag_byte), .mode_control_byte(mode_byte),
    .status_read(status_read), .fault_spk(fault_spk), .fault_boost_load(boost_load),
    .short_event(short_ev), .channel1_status_byte(status_byte), .chan_fault(chan_fault),
    .mode(mode), .outputs_hiz(hiz), .chan_mute(chan_mute), .enable_pin_out(pin_out),
    .enable_pin_oe(pin_oe), .enable_pin_source(pin_src), .diag_busy(busy),
    .booster_sel(booster_sel));
  // compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // bounded wait for busy to reach a level; returns cycles spent
  task automatic wait_busy(input logic v, output int n);
    for (n = 0; n < 400 && busy !== v; n++) @(negedge clk);
    check("busy", busy, v);
  endtask : wait_busy
  task automatic t_standby();
    repeat (5) @(negedge clk);
    check("mode", mode, AMD_STANDBY);
    check("hiz", hiz, 1'b1);
    host.write_bytes(8'h80, 8'h00);
    repeat (10) @(negedge clk);
    check("busy", busy, 1'b0);
    host.write_bytes(8'h00, 8'h00);
  endtask : t_standby
  task automatic t_diag();
    int n;
    host.set_en(1'b1);
    repeat (5) @(negedge clk);
    check("mode", mode, AMD_TRISTATE);
    check("hiz", hiz, 1'b1);
    fault_spk = {5'h01, 5'h01, 5'h08, 5'h10};
    boost_load = 4'h4;
    host.write_bytes(8'hc0, 8'h00);
    wait_busy(1'b1, n);
    check("booster", booster_sel, 4'h5);
    host.write_bytes(8'h40, 8'h00);
    host.write_bytes(8'hc0, 8'h00);
    repeat (2) @(negedge clk);
    check("busy", busy, 1'b1);
    wait_busy(1'b0, n);
    check("span", (n >= 100 && n <= 170), 1'b1);
    check("valid", status_byte[6], 1'b1);
    check("ch1 code", status_byte[4:0], 5'h10);
    check("ch2", chan_fault[1], 5'h08);
    check("ch4", chan_fault[3], 5'h01);
    check("ch3 load", chan_fault[2].short_load, 1'b1);
    fault_spk = '0;
    repeat (20) @(negedge clk);
    check("ch2 kept", chan_fault[1], 5'h08);
    check("busy", busy, 1'b0);
  endtask : t_diag
  task automatic t_read();
    host.read_status();
    repeat (3) @(negedge clk);
    check("status", status_byte, 8'h00);
  endtask : t_read
  task automatic t_amp();
    int n;
    host.write_bytes(8'h00, 8'h00);
    host.write_bytes(8'h80, 8'h80);
    wait_busy(1'b1, n);
    wait_busy(1'b0, n);
    repeat (3) @(negedge clk);
    check("mode", mode, AMD_AMPLIFIER);
    check("active", status_byte[7], 1'b1);
    check("hiz", hiz, 1'b0);
    check("mute", chan_mute, 4'hf);
    check("oe", pin_oe, 1'b1);
    short_ev = 4'h4;
    @(negedge clk);
    short_ev = 4'h0;
    @(negedge clk);
    check("ch3 short", chan_fault[2], 5'h04);
    check("ch2 amp", chan_fault[1], 5'h00);
    host.write_bytes(8'h00, 8'h80);
    host.write_bytes(8'h80, 8'h80);
    repeat (10) @(negedge clk);
    check("busy", busy, 1'b0);
  endtask : t_amp
  task automatic t_off();
    logic seen;
    seen = 1'b0;
    host.set_en(1'b0);
    repeat (30) begin
      @(negedge clk);
      seen = seen | (pin_src === 1'b1);
    end
    check("source", seen, 1'b1);
    check("mode", mode, AMD_STANDBY);
  endtask : t_off
  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  // main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_standby();
    t_diag();
    t_read();
    t_amp();
    t_off();
    stop_test();
  end
  // watchdog against a hang
  initial begin
    #100us;
    n_fail++;
    stop_test();
  end
endmodule : tb_top
